// ==== rtcib_pkg.sv ====
// Constants and types for the clock-register indirect access bridge
package rtcib_pkg;

  // Bridge register selects on the special function register bus
  localparam logic [1:0] SEL_KEY = 2'h0;
  localparam logic [1:0] SEL_ADR = 2'h1;
  localparam logic [1:0] SEL_DAT = 2'h2;

  // Address register field positions
  localparam int ADR_BUSY_BIT = 7;
  localparam int ADR_SEQUENTIAL_READ_ENABLE_BIT = 6;
  localparam int ADR_SHORT_BIT = 4;
  localparam int ADR_IDX_MSB = 3;

  // Internal register indices
  localparam logic [3:0] IDX_CAPTURE0 = 4'h0;
  localparam logic [3:0] IDX_CLOCK_CTRL = 4'h4;
  localparam logic [3:0] IDX_OSC_CTRL = 4'h5;
  localparam logic [3:0] IDX_OSC_CFG = 4'h6;
  localparam logic [3:0] IDX_HOLE = 4'h7;
  localparam logic [3:0] IDX_ALARM0 = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'hB;
  localparam int NUM_ENTRIES = 12;

  // Reset values
  localparam logic SHORT_RESET = 1'h1;
  localparam logic [7:0] ENTRY_RESET = 8'h00;

  // Access durations in system clock cycles
  localparam logic [2:0] OP_CYCLES_LONG = 3'h7;
  localparam logic [2:0] OP_CYCLES_SHORT = 3'h6;

  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} rtcib_op_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } rtcib_sfr_req_s;

  typedef struct packed {
    logic [31:0] capture;
    logic [7:0] clock_ctrl;
    logic [7:0] osc_ctrl;
    logic [7:0] osc_cfg;
    logic [31:0] alarm;
  } rtcib_clk_regs_s;

endpackage

// ==== rtcib_regbank.sv ====
// Internal clock register bank reached by the bridge
`timescale 1ns/10ps
module rtcib_regbank #(
  parameter int IDX_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Indirect access port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Register contents toward the clock core
  output rtcib_pkg::rtcib_clk_regs_s regs
);

  logic [7:0] mem_q [rtcib_pkg::NUM_ENTRIES];
  logic idx_ok;

  // Index 7 and anything past the alarm bytes is a hole
  assign idx_ok = (idx <= IDX_W'(rtcib_pkg::IDX_LAST)) &&
                  (idx != IDX_W'(rtcib_pkg::IDX_HOLE));

  // Every mapped entry is its own byte register
  for (genvar i = 0; i < rtcib_pkg::NUM_ENTRIES; i++) begin : g_entry
    logic hit;
    assign hit = wr_en && idx_ok && (idx == IDX_W'(i));
    always_ff @(posedge clk) begin
      if (rst) begin
        mem_q[i] <= rtcib_pkg::ENTRY_RESET;
      end else if (hit) begin
        mem_q[i] <= wdata;
      end
    end
  end

  assign rdata = idx_ok ? mem_q[idx] : 8'h00;

  assign regs.capture = {mem_q[3], mem_q[2], mem_q[1],
                         mem_q[rtcib_pkg::IDX_CAPTURE0]};
  assign regs.clock_ctrl = mem_q[rtcib_pkg::IDX_CLOCK_CTRL];
  assign regs.osc_ctrl = mem_q[rtcib_pkg::IDX_OSC_CTRL];
  assign regs.osc_cfg = mem_q[rtcib_pkg::IDX_OSC_CFG];
  assign regs.alarm = {mem_q[11], mem_q[10], mem_q[9],
                       mem_q[rtcib_pkg::IDX_ALARM0]};

endmodule

// ==== rtcib_bridge.sv ====
// Indirect access bridge from the core's register bus to the clock
`timescale 1ns/10ps
module rtcib_bridge #(
  parameter int IDX_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Special function register bus
  input wire rtcib_pkg::rtcib_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata_q,
  // Clock register contents
  output rtcib_pkg::rtcib_clk_regs_s clk_regs,
  // Bridge state
  output logic busy_q
);

  if (IDX_W != 4) begin : g_bad_idx
    $error("rtcib_bridge: index width must be 4");
  end

  // Address register fields
  logic [IDX_W-1:0] index_q;
  logic sequential_read_enable_q;
  logic short_q;
  logic short_d;
  // Data register
  logic [7:0] dat_q;
  logic [7:0] dat_d;
  // Sequencer
  rtcib_pkg::rtcib_op_e op_q;
  rtcib_pkg::rtcib_op_e op_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic busy_d;
  logic [2:0] len_q;
  logic [2:0] len_d;
  logic [7:0] sfr_rdata_d;

  // Bus decode
  logic wr_key;
  logic wr_adr;
  logic wr_dat;
  logic rd_adr;
  logic rd_dat;
  assign wr_key = sfr_req.wr && (sfr_req.sel == rtcib_pkg::SEL_KEY);
  assign wr_adr = sfr_req.wr && (sfr_req.sel == rtcib_pkg::SEL_ADR);
  assign wr_dat = sfr_req.wr && (sfr_req.sel == rtcib_pkg::SEL_DAT);
  assign rd_adr = sfr_req.rd && (sfr_req.sel == rtcib_pkg::SEL_ADR);
  assign rd_dat = sfr_req.rd && (sfr_req.sel == rtcib_pkg::SEL_DAT);

  // Start conditions; a start while busy is dropped
  logic start_wr;
  logic start_rd_busy;
  logic start_rd_auto;
  logic start_rd;
  logic start_any;
  logic done;
  assign start_wr = wr_dat && !busy_q;
  assign start_rd_busy = wr_adr && sfr_req.wdata[rtcib_pkg::ADR_BUSY_BIT]
                         && !busy_q;
  assign start_rd_auto = rd_dat && sequential_read_enable_q && !busy_q;
  assign start_rd = start_rd_busy || start_rd_auto;
  assign start_any = start_wr || start_rd;
  assign done = busy_q && (cnt_q == 3'h0);

  // Address register as seen by the core; bit 5 reads zero
  logic [7:0] adr_view;
  assign adr_view = {busy_q, sequential_read_enable_q, 1'b0, short_q,
                     index_q};

  // Internal bank
  logic [7:0] bank_rdata;
  logic bank_wr;
  assign bank_wr = done && (op_q == rtcib_pkg::OP_WRITE);

  rtcib_regbank #(
    .IDX_W(IDX_W)
  ) u_bank (
    .clk(clk),
    .rst(rst),
    .wr_en(bank_wr),
    .idx(index_q),
    .wdata(dat_q),
    .rdata(bank_rdata),
    .regs(clk_regs)
  );

  // Short strobe picks the duration at the start of each access
  logic [2:0] start_len;
  assign start_len = short_d ? rtcib_pkg::OP_CYCLES_SHORT
                             : rtcib_pkg::OP_CYCLES_LONG;

  // Short strobe next value
  assign short_d = wr_adr ? sfr_req.wdata[rtcib_pkg::ADR_SHORT_BIT]
                          : short_q;

  // Data register: core write, or captured read result
  always_comb begin
    dat_d = dat_q;
    if (done && (op_q == rtcib_pkg::OP_READ)) begin
      dat_d = bank_rdata;
    end else if (start_wr) begin
      dat_d = sfr_req.wdata;
    end
  end

  // Sequencer next state
  always_comb begin
    op_d = op_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    len_d = len_q;
    if (start_any) begin
      op_d = start_wr ? rtcib_pkg::OP_WRITE : rtcib_pkg::OP_READ;
      cnt_d = start_len - 3'h1;
      busy_d = 1'b1;
      len_d = start_len;
    end else if (done) begin
      op_d = rtcib_pkg::OP_IDLE;
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - 3'h1;
    end
  end

  // Read data mux, registered so the output is a flop
  always_comb begin
    sfr_rdata_d = 8'h00;
    unique case (sfr_req.sel)
      rtcib_pkg::SEL_ADR: sfr_rdata_d = adr_view;
      rtcib_pkg::SEL_DAT: sfr_rdata_d = dat_q;
      default: sfr_rdata_d = 8'h00;
    endcase
  end

  // Index and auto-read bits are kept through reset
  always_ff @(posedge clk) begin
    if (wr_adr) begin
      index_q <= sfr_req.wdata[rtcib_pkg::ADR_IDX_MSB:0];
      sequential_read_enable_q <= sfr_req.wdata[rtcib_pkg::ADR_SEQUENTIAL_READ_ENABLE_BIT];
    end
  end

  // Data register is kept through reset
  always_ff @(posedge clk) begin
    dat_q <= dat_d;
  end

  // Key writes touch nothing; the interface is always open
  always_ff @(posedge clk) begin
    if (rst) begin
      short_q <= rtcib_pkg::SHORT_RESET;
    end else begin
      short_q <= short_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= rtcib_pkg::OP_IDLE;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      len_q <= 3'h0;
    end else begin
      op_q <= op_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      len_q <= len_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_req.rd) begin
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Helper: bank data sampled at completion of a write
  logic [7:0] last_wr_data_q;
  logic [IDX_W-1:0] last_wr_idx_q;
  always_ff @(posedge clk) begin
    if (bank_wr) begin
      last_wr_data_q <= dat_q;
      last_wr_idx_q <= index_q;
    end
  end

  AST_KEY_IGNORED: assert property (
    wr_key && !busy_q |=> $stable(index_q) && $stable(dat_q) &&
      $stable(short_q) && !busy_q)
    else $error("key write changed bridge state");

  AST_WRITE_START: assert property (
    start_wr |=> busy_q && (op_q == rtcib_pkg::OP_WRITE) &&
      (dat_q == $past(sfr_req.wdata)))
    else $error("data write did not start indirect write");

  AST_READ_START: assert property (
    start_rd_busy |=> busy_q && (op_q == rtcib_pkg::OP_READ))
    else $error("setting busy did not start indirect read");

  AST_SEQUENTIAL_READ_ENABLE_START: assert property (
    rd_dat && sequential_read_enable_q && !busy_q |=> busy_q &&
      (op_q == rtcib_pkg::OP_READ))
    else $error("auto-read did not launch next read");

  AST_LONG_LEN: assert property (
    start_any && (start_len == rtcib_pkg::OP_CYCLES_LONG) |=>
      busy_q [*7] ##1 !busy_q)
    else $error("long access not seven cycles");

  AST_SHORT_LEN: assert property (
    start_any && (start_len == rtcib_pkg::OP_CYCLES_SHORT) |=>
      busy_q [*6] ##1 !busy_q)
    else $error("short access not six cycles");

  AST_READ_LOAD: assert property (
    done && (op_q == rtcib_pkg::OP_READ) |=>
      (dat_q == $past(bank_rdata)) && !busy_q)
    else $error("read result not copied to data register");

  AST_DAT_HOLD: assert property (
    !done && !start_wr |=> $stable(dat_q))
    else $error("data register changed outside an operation");

  AST_BUSY_VIEW: assert property (
    rd_adr |=> sfr_rdata_q[rtcib_pkg::ADR_BUSY_BIT] == $past(busy_q))
    else $error("busy flag not shown in address bit 7");

  AST_WRITE_COMMIT: assert property (
    bank_wr ##1 (index_q == last_wr_idx_q) |->
      (bank_rdata == last_wr_data_q) ||
      (last_wr_idx_q == IDX_W'(rtcib_pkg::IDX_HOLE)) ||
      (last_wr_idx_q > IDX_W'(rtcib_pkg::IDX_LAST)))
    else $error("indirect write did not reach internal register");

  AST_SHORT_RESET: assert property (
    @(posedge clk) $past(rst) |-> short_q && !busy_q)
    else $error("short strobe not enabled after reset");

  AST_CNT_RANGE: assert property (
    busy_q |-> cnt_q < len_q)
    else $error("access counter outside its duration");

  AST_INDEX_SELECT: assert property (
    wr_adr |=> index_q == $past(sfr_req.wdata[rtcib_pkg::ADR_IDX_MSB:0]))
    else $error("address write did not select the index");

  AST_ADR_VIEW: assert property (
    rd_adr |=> sfr_rdata_q[rtcib_pkg::ADR_IDX_MSB:0] == $past(index_q))
    else $error("index not shown in address low bits");

  COV_WRITE: cover property (start_wr ##[6:7] !busy_q);
  COV_READ: cover property (start_rd_busy ##[6:7] !busy_q);
  COV_SEQUENTIAL_READ_ENABLE_RUN: cover property (
    start_rd_auto ##[6:7] !busy_q ##[1:4] start_rd_auto);
  COV_LONG: cover property (
    start_any && (start_len == rtcib_pkg::OP_CYCLES_LONG));

endmodule

// ==== rtcib_core_model.sv ====
// Processor core model driving the bridge register bus
`timescale 1ns/10ps
module rtcib_core_model (
  // Clock
  input wire logic clk,
  // Register bus
  output rtcib_pkg::rtcib_sfr_req_s sfr_req,
  input wire logic [7:0] sfr_rdata_q
);
  initial sfr_req = '0;

  // Strobe left up so calls can run back to back
  task automatic op(input logic w, input logic [1:0] s, input logic [7:0] d);
    sfr_req = {w, !w, s, d};
    @(posedge clk);
    #1;
  endtask

  // Released data is inverted, so a second idle in a row shows the last byte again
  task automatic idle(input int n);
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
    sfr_req.wdata = ~sfr_req.wdata;
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the clock register indirect access bridge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rtcib_pkg::rtcib_sfr_req_s sfr_req;
  logic [7:0] sfr_rdata_q;
  rtcib_pkg::rtcib_clk_regs_s clk_regs;
  logic busy_q;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [7:0] v;

  initial forever #25 clk = ~clk;

  rtcib_core_model core (.clk(clk), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q));
  rtcib_bridge dut (.clk(clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q), .clk_regs(clk_regs), .busy_q(busy_q));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic wadr(input logic [7:0] d);
    core.op(1'b1, rtcib_pkg::SEL_ADR, d);
  endtask

  task automatic rdat(output logic [7:0] d);
    core.op(1'b0, rtcib_pkg::SEL_DAT, 8'h00);
    d = sfr_rdata_q;
  endtask

  // Edges counted until busy drops, bounded
  task automatic wait_idle(output int k);
    k = 0;
    core.idle(0);
    while (busy_q === 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic t_reset();
    `CHK("busy", 1'b0, busy_q)
    `CHK("bank", 88'h0, clk_regs)
    core.op(1'b0, rtcib_pkg::SEL_ADR, 8'h00);
    `CHK("short", 1'b1, sfr_rdata_q[4])
    `CHK("adr rst", 8'h10, sfr_rdata_q)
    core.op(1'b0, 2'h3, 8'h00);
    `CHK("unmapped", 8'h00, sfr_rdata_q)
    rdat(v);
    `CHK("dat rst", 8'h00, v)
    core.idle(1);
    $display("t_reset done");
  endtask

  task automatic t_write();
    core.op(1'b1, rtcib_pkg::SEL_KEY, 8'h5A);
    for (int i = 0; i < 12; i++) begin
      wadr(8'h10 | 8'(i));
      core.op(1'b1, rtcib_pkg::SEL_DAT, 8'hA0 + 8'(i));
      wait_idle(n);
      if (i != 7) `CHK("wr cycles", 6, n)
    end
    `CHK("bank", 88'hA3A2A1A0_A4A5A6_ABAAA9A8, clk_regs)
    $display("t_write done");
  endtask

  task automatic t_read();
    for (int i = 0; i < 12; i++) begin
      wadr(8'h80 | 8'(i));
      wait_idle(n);
      rdat(v);
      `CHK("rd data", (i == 7) ? 8'h00 : 8'hA0 + 8'(i), v)
      if (i != 7) `CHK("rd cycles", 7, n)
    end
    $display("t_read done");
  endtask

  // Fixed spacing instead of polling; bus cycles stand for instructions
  task automatic t_nopoll();
    wadr(8'h95);
    core.idle(6);
    rdat(v);
    `CHK("nopoll data", 8'hA5, v)
    wadr(8'h16);
    core.op(1'b1, rtcib_pkg::SEL_DAT, 8'h5C);
    // Second write lands while busy and must be dropped
    core.op(1'b1, rtcib_pkg::SEL_DAT, 8'h33);
    core.idle(5);
    `CHK("nopoll cfg", 8'h5C, clk_regs.osc_cfg)
    `CHK("nopoll busy", 1'b0, busy_q)
    rdat(v);
    `CHK("dropped", 8'h5C, v)
    $display("t_nopoll done");
  endtask

  task automatic t_auto();
    wadr(8'hD5);
    core.op(1'b0, rtcib_pkg::SEL_ADR, 8'h00);
    `CHK("adr", 8'hD5, sfr_rdata_q)
    wait_idle(n);
    // One edge already spent on the address readback
    `CHK("busy left", 5, n)
    rdat(v);
    `CHK("auto data", 8'hA5, v)
    `CHK("auto busy", 1'b1, busy_q)
    wait_idle(n);
    `CHK("auto cycles", 6, n)
    rdat(v);
    `CHK("auto data2", 8'hA5, v)
    $display("t_auto done");
  endtask

  task automatic t_retain();
    wadr(8'h05);
    wait_idle(n);
    rst = 1'b1;
    core.idle(2);
    rst = 1'b0;
    `CHK("bank rst", 88'h0, clk_regs)
    core.op(1'b0, rtcib_pkg::SEL_ADR, 8'h00);
    `CHK("adr kept", 8'h15, sfr_rdata_q)
    rdat(v);
    `CHK("dat kept", 8'hA5, v)
    core.idle(1);
    $display("t_retain done");
  endtask

  initial begin
    repeat (7) @(posedge clk);
    #1;
    // Index, auto-read and data registers survive reset, so seed them while it is held
    wadr(8'h10);
    core.op(1'b1, rtcib_pkg::SEL_DAT, 8'h00);
    core.idle(1);
    rst = 1'b0;
    t_reset();
    t_write();
    t_read();
    t_nopoll();
    t_auto();
    t_retain();
    give_verdict();
  end
endmodule
